//--- logic/tpsl_pkg.sv
// Constants shared by the transmit pulse-shape and line-driver control block.
package tpsl_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] REG_TERM_IDX = 6'h03;
  localparam logic [5:0] REG_TXCFG0_IDX = 6'h05;
  localparam logic [5:0] REG_TXCFG1_IDX = 6'h06;
  localparam logic [5:0] REG_STATUS_IDX = 6'h07;
  localparam logic [5:0] REG_SOFTRST_IDX = 6'h08;

  // ==========================================================================
  // Field positions.
  localparam int TXCFG0_POWER_OFF_BIT = 4;
  localparam int TXCFG1_HIGH_Z_BIT = 6;
  localparam int SOFTRST_BIT = 0;
  localparam int TERM_EXTERNAL_BIT = 2;

  // ==========================================================================
  // Values after reset.
  localparam logic [2:0] TERM_RST = 3'h0;
  localparam logic [3:0] TEMPLATE_RST = 4'h0;
  localparam logic POWER_OFF_RST = 1'b0;
  localparam logic HIGH_Z_RST = 1'b0;
  localparam logic [5:0] SCALE_RST = 6'h36;

  // ==========================================================================
  // Pulse templates and their amplitude scale defaults.
  localparam logic [3:0] TPL_E1_75 = 4'h0;
  localparam logic [3:0] TPL_E1_120 = 4'h1;
  localparam logic [3:0] TPL_J1 = 4'h7;
  localparam logic [3:0] TPL_LBO_0 = 4'h8;
  localparam logic [3:0] TPL_LBO_7P5 = 4'h9;
  localparam logic [3:0] TPL_LBO_15 = 4'ha;
  localparam logic [3:0] TPL_LBO_22P5 = 4'hb;
  localparam logic [5:0] SCALE_DEF_0DB = 6'h36;
  localparam logic [5:0] SCALE_DEF_7P5 = 6'h11;
  localparam logic [5:0] SCALE_DEF_15 = 6'h08;
  localparam logic [5:0] SCALE_DEF_22P5 = 6'h04;

  // Impedance codes.
  localparam logic [1:0] IMP_75 = 2'h0;
  localparam logic [1:0] IMP_120 = 2'h1;
  localparam logic [1:0] IMP_100 = 2'h2;
  localparam logic [1:0] IMP_110 = 2'h3;

  // Table selector for the waveform store.
  typedef enum logic [1:0] {
    LBO_7P5 = 2'b00,
    LBO_15 = 2'b01,
    LBO_22P5 = 2'b10,
    LBO_NONE = 2'b11
  } tpsl_lbo_t;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRANSMIT_CLOCK_LOSS_NS = 2000;
  localparam logic [6:0] TRANSMIT_CLOCK_LOSS_CYCLES = 7'(TRANSMIT_CLOCK_LOSS_NS / CLK_PERIOD_NS);
  localparam logic [3:0] LAST_SAMPLE = 4'hf;

  // ==========================================================================
  // Positions of the pin inputs inside the synchroniser vector.
  localparam int PIN_HW_MODE = 0;
  localparam int PIN_TERM = 1;
  localparam int PIN_TPL_LO = 2;
  localparam int PIN_HIGH_Z = 6;
  localparam int PIN_PATT_HI = 7;
  localparam int PIN_PATT_LO = 8;
  localparam int PIN_TRANSMIT_CLOCK = 9;
  localparam int PIN_MCLK_LOST = 10;
  localparam int PIN_COUNT = 11;

endpackage

//--- logic/tpsl_wave_rom.sv
// Stored long-haul build-out pulse samples, one row of four unit intervals per sample.
`timescale 1ns/1ps
module tpsl_wave_rom import tpsl_pkg::*; (
  // Lookup
  input wire tpsl_lbo_t lboSel,
  input wire logic [3:0] sampleIdx,
  // Samples for unit intervals 1 to 4, interval 1 in the top bits
  output logic [27:0] uiRow
);

  always_comb begin
    case ({lboSel, sampleIdx})
      // -7.5 dB build-out.
      6'h00: uiRow = {7'h00, 7'h14, 7'h02, 7'h00};
      6'h01: uiRow = {7'h02, 7'h12, 7'h02, 7'h00};
      6'h02: uiRow = {7'h09, 7'h10, 7'h02, 7'h00};
      6'h03: uiRow = {7'h13, 7'h0e, 7'h02, 7'h00};
      6'h04: uiRow = {7'h1d, 7'h0c, 7'h02, 7'h00};
      6'h05: uiRow = {7'h25, 7'h0b, 7'h01, 7'h00};
      6'h06: uiRow = {7'h2b, 7'h0a, 7'h01, 7'h00};
      6'h07: uiRow = {7'h31, 7'h09, 7'h01, 7'h00};
      6'h08: uiRow = {7'h36, 7'h08, 7'h01, 7'h00};
      6'h09: uiRow = {7'h3a, 7'h07, 7'h01, 7'h00};
      6'h0a: uiRow = {7'h39, 7'h06, 7'h01, 7'h00};
      6'h0b: uiRow = {7'h30, 7'h05, 7'h01, 7'h00};
      6'h0c: uiRow = {7'h28, 7'h04, 7'h00, 7'h00};
      6'h0d: uiRow = {7'h20, 7'h04, 7'h00, 7'h00};
      6'h0e: uiRow = {7'h1a, 7'h03, 7'h00, 7'h00};
      6'h0f: uiRow = {7'h17, 7'h03, 7'h00, 7'h00};
      // -15.0 dB build-out.
      6'h10: uiRow = {7'h00, 7'h35, 7'h0f, 7'h03};
      6'h11: uiRow = {7'h00, 7'h33, 7'h0d, 7'h02};
      6'h12: uiRow = {7'h00, 7'h30, 7'h0c, 7'h02};
      6'h13: uiRow = {7'h01, 7'h2d, 7'h0b, 7'h02};
      6'h14: uiRow = {7'h04, 7'h2a, 7'h0a, 7'h02};
      6'h15: uiRow = {7'h08, 7'h27, 7'h09, 7'h01};
      6'h16: uiRow = {7'h0e, 7'h24, 7'h08, 7'h01};
      6'h17: uiRow = {7'h14, 7'h21, 7'h07, 7'h01};
      6'h18: uiRow = {7'h1b, 7'h1e, 7'h06, 7'h01};
      6'h19: uiRow = {7'h22, 7'h1c, 7'h06, 7'h01};
      6'h1a: uiRow = {7'h2a, 7'h1a, 7'h05, 7'h01};
      6'h1b: uiRow = {7'h30, 7'h17, 7'h05, 7'h01};
      6'h1c: uiRow = {7'h35, 7'h15, 7'h04, 7'h01};
      6'h1d: uiRow = {7'h37, 7'h14, 7'h04, 7'h00};
      6'h1e: uiRow = {7'h38, 7'h12, 7'h03, 7'h00};
      6'h1f: uiRow = {7'h37, 7'h10, 7'h03, 7'h00};
      // -22.5 dB build-out.
      6'h20: uiRow = {7'h00, 7'h2c, 7'h1e, 7'h08};
      6'h21: uiRow = {7'h00, 7'h2e, 7'h1c, 7'h07};
      6'h22: uiRow = {7'h00, 7'h30, 7'h1a, 7'h06};
      6'h23: uiRow = {7'h00, 7'h31, 7'h18, 7'h05};
      6'h24: uiRow = {7'h01, 7'h32, 7'h17, 7'h05};
      6'h25: uiRow = {7'h03, 7'h32, 7'h15, 7'h04};
      6'h26: uiRow = {7'h07, 7'h32, 7'h14, 7'h04};
      6'h27: uiRow = {7'h0b, 7'h31, 7'h13, 7'h03};
      6'h28: uiRow = {7'h0f, 7'h30, 7'h11, 7'h03};
      6'h29: uiRow = {7'h15, 7'h2e, 7'h10, 7'h02};
      6'h2a: uiRow = {7'h19, 7'h2c, 7'h0f, 7'h02};
      6'h2b: uiRow = {7'h1c, 7'h29, 7'h0e, 7'h02};
      6'h2c: uiRow = {7'h20, 7'h27, 7'h0d, 7'h01};
      6'h2d: uiRow = {7'h23, 7'h24, 7'h0c, 7'h01};
      6'h2e: uiRow = {7'h27, 7'h22, 7'h0a, 7'h01};
      6'h2f: uiRow = {7'h2a, 7'h20, 7'h09, 7'h01};
      default: uiRow = 28'h0000000;
    endcase
  end

endmodule // tpsl_wave_rom

//--- logic/tpsl_tx_line_ctrl.sv
// Transmit pulse shaping for the -7.5, -15 and -22.5 dB build-out templates, termination select, line driver tri-state and power down with AHB-Lite registers.
`timescale 1ns/1ps
module tpsl_tx_line_ctrl import tpsl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Hardware control pins
  input wire logic hwControlMode,
  input wire logic terminationModePin,
  input wire logic [3:0] pulseTemplatePins,
  input wire logic txHighZPin,
  input wire logic patternSelectHi,
  input wire logic patternSelectLo,
  // Clock monitors and transmit modes
  input wire logic transmitClock,
  input wire logic masterClockLost,
  input wire logic remoteLoopback,
  input wire logic internalPatternByMclk,
  // Encoded transmit marks
  input wire logic txMarkPos,
  input wire logic txMarkNeg,
  // Line driver
  output logic lineOutPosDrive,
  output logic lineOutPosOe,
  output logic lineOutNegDrive,
  output logic lineOutNegOe,
  output logic signed [13:0] lineDacCode,
  output logic txPowerDown,
  output logic internalTermEnable,
  output logic [1:0] termImpedanceSel
);

  // ==========================================================================
  // Decoding helpers
  function automatic logic [5:0] scaleDefault(input logic [3:0] tpl);
    case (tpl)
      TPL_LBO_7P5: scaleDefault = SCALE_DEF_7P5;
      TPL_LBO_15: scaleDefault = SCALE_DEF_15;
      TPL_LBO_22P5: scaleDefault = SCALE_DEF_22P5;
      default: scaleDefault = SCALE_DEF_0DB;
    endcase
  endfunction

  function automatic logic [1:0] templateImpedance(input logic [3:0] tpl);
    case (tpl)
      TPL_E1_75: templateImpedance = IMP_75;
      TPL_E1_120: templateImpedance = IMP_120;
      TPL_J1: templateImpedance = IMP_110;
      default: templateImpedance = IMP_100;
    endcase
  endfunction

  function automatic tpsl_lbo_t templateLbo(input logic [3:0] tpl);
    case (tpl)
      TPL_LBO_7P5: templateLbo = LBO_7P5;
      TPL_LBO_15: templateLbo = LBO_15;
      TPL_LBO_22P5: templateLbo = LBO_22P5;
      default: templateLbo = LBO_NONE;
    endcase
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [PIN_COUNT-1:0] pinMeta;
  logic [PIN_COUNT-1:0] pinSync;
  logic tclkPrev;
  logic [6:0] tclkIdle;
  logic [6:0] next_tclkIdle;
  logic tclkRise;
  logic tclkLost;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
      tclkPrev <= 1'b0;
      tclkIdle <= '0;
    end else begin
      pinMeta <= {masterClockLost, transmitClock, patternSelectLo, patternSelectHi, txHighZPin,
                  pulseTemplatePins, terminationModePin, hwControlMode};
      pinSync <= pinMeta;
      tclkPrev <= pinSync[PIN_TRANSMIT_CLOCK];
      tclkIdle <= next_tclkIdle;
    end
  end

  assign tclkRise = pinSync[PIN_TRANSMIT_CLOCK] & ~tclkPrev;
  assign tclkLost = (tclkIdle >= TRANSMIT_CLOCK_LOSS_CYCLES);

  always_comb begin
    if (tclkRise) begin
      next_tclkIdle = '0;
    end else if (tclkLost) begin
      next_tclkIdle = tclkIdle;
    end else begin
      next_tclkIdle = tclkIdle + 7'h01;
    end
  end

  // ==========================================================================
  // Bus slave and registers
  logic dpValid;
  logic dpWrite;
  logic [5:0] dpIndex;
  logic [2:0] termSel;
  logic [3:0] templateSel;
  logic powerOff;
  logic highZ;
  logic [5:0] amplitudeScale;
  logic resetHold;
  logic next_dpValid;
  logic next_dpWrite;
  logic [5:0] next_dpIndex;
  logic [2:0] next_termSel;
  logic [3:0] next_templateSel;
  logic next_powerOff;
  logic next_highZ;
  logic [5:0] next_amplitudeScale;
  logic next_resetHold;
  logic [31:0] next_hrdata;
  logic [7:0] statusWord;
  logic addrMapped;

  assign addrMapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

  always_comb begin
    next_dpValid = hsel & htrans[1] & hready & addrMapped;
    next_dpWrite = hwrite;
    next_dpIndex = haddr[7:2];
    next_termSel = termSel;
    next_templateSel = templateSel;
    next_powerOff = powerOff;
    next_highZ = highZ;
    next_amplitudeScale = amplitudeScale;
    next_resetHold = resetHold & ~tclkRise;
    if (dpValid && dpWrite) begin
      case (dpIndex)
        REG_TERM_IDX: next_termSel = hwdata[2:0];
        REG_TXCFG0_IDX: begin
          next_templateSel = hwdata[3:0];
          next_powerOff = hwdata[TXCFG0_POWER_OFF_BIT];
          if (hwdata[3:0] != templateSel) begin
            next_amplitudeScale = scaleDefault(hwdata[3:0]);
          end
        end
        REG_TXCFG1_IDX: begin
          next_highZ = hwdata[TXCFG1_HIGH_Z_BIT];
          next_amplitudeScale = hwdata[5:0];
        end
        REG_SOFTRST_IDX: begin
          if (hwdata[SOFTRST_BIT]) begin
            next_termSel = TERM_RST;
            next_templateSel = TEMPLATE_RST;
            next_powerOff = POWER_OFF_RST;
            next_highZ = HIGH_Z_RST;
            next_amplitudeScale = SCALE_RST;
            next_resetHold = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Reads use the next values so that a read right after a write sees the new data.
    next_hrdata = 32'h00000000;
    if (next_dpValid && !hwrite) begin
      case (next_dpIndex)
        REG_TERM_IDX: next_hrdata = {29'h0, next_termSel};
        REG_TXCFG0_IDX: next_hrdata = {27'h0, next_powerOff, next_templateSel};
        REG_TXCFG1_IDX: next_hrdata = {25'h0, next_highZ, next_amplitudeScale};
        REG_STATUS_IDX: next_hrdata = {24'h0, statusWord};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpIndex <= '0;
      termSel <= TERM_RST;
      templateSel <= TEMPLATE_RST;
      powerOff <= POWER_OFF_RST;
      highZ <= HIGH_Z_RST;
      amplitudeScale <= SCALE_RST;
      resetHold <= 1'b1;
      hrdata <= 32'h00000000;
    end else begin
      dpValid <= next_dpValid;
      dpWrite <= next_dpWrite;
      dpIndex <= next_dpIndex;
      termSel <= next_termSel;
      templateSel <= next_templateSel;
      powerOff <= next_powerOff;
      highZ <= next_highZ;
      amplitudeScale <= next_amplitudeScale;
      resetHold <= next_resetHold;
      hrdata <= next_hrdata;
    end
  end

  // Every transfer completes without wait states and with an OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // Effective controls, from registers or from pins
  logic hwMode;
  logic [3:0] effTemplate;
  logic [5:0] effScale;
  logic effPowerDown;
  logic effHighZReq;
  logic effInternalTerm;
  logic [1:0] effImpedance;
  logic lineHighZ;
  logic unsupportedTerm;

  assign hwMode = pinSync[PIN_HW_MODE];
  assign effTemplate = hwMode ? pinSync[PIN_TPL_LO +: 4] : templateSel;
  assign effScale = hwMode ? scaleDefault(effTemplate) : amplitudeScale;
  assign effPowerDown = hwMode ? (pinSync[PIN_PATT_HI] & pinSync[PIN_PATT_LO]) : powerOff;
  assign effHighZReq = hwMode ? pinSync[PIN_HIGH_Z] : highZ;
  assign effInternalTerm = hwMode ? pinSync[PIN_TERM] : ~termSel[TERM_EXTERNAL_BIT];
  assign effImpedance = hwMode ? templateImpedance(effTemplate) : termSel[1:0];
  assign lineHighZ = resetHold | pinSync[PIN_MCLK_LOST] | effPowerDown | effHighZReq
                   | (tclkLost & ~remoteLoopback & ~internalPatternByMclk);
  // External termination is not supported with the T1 or J1 templates; flagged only.
  assign unsupportedTerm = ~effInternalTerm & (effTemplate > TPL_E1_120);
  assign statusWord = {unsupportedTerm, effImpedance, effInternalTerm, effPowerDown,
                       pinSync[PIN_MCLK_LOST], tclkLost, lineHighZ};

  // ==========================================================================
  // Waveform generator
  logic [3:0] sampleIdx;
  logic [3:0] histPos;
  logic [3:0] histNeg;
  logic [3:0] next_sampleIdx;
  logic [3:0] next_histPos;
  logic [3:0] next_histNeg;
  tpsl_lbo_t lboSel;
  logic [27:0] uiRow;
  logic signed [9:0] pulseSum;
  logic [6:0] scaleNum;
  logic signed [16:0] scaledProd;
  logic signed [16:0] scaledOut;
  logic signed [13:0] next_dacCode;

  assign lboSel = templateLbo(effTemplate);

  tpsl_wave_rom u_wave_rom (
    .lboSel(lboSel),
    .sampleIdx(sampleIdx),
    .uiRow(uiRow)
  );

  always_comb begin
    next_sampleIdx = (sampleIdx == LAST_SAMPLE) ? sampleIdx : sampleIdx + 4'h1;
    next_histPos = histPos;
    next_histNeg = histNeg;
    if (effPowerDown) begin
      next_histPos = 4'h0;
      next_histNeg = 4'h0;
    end else if (tclkRise) begin
      next_sampleIdx = 4'h0;
      next_histPos = {histPos[2:0], txMarkPos & ~txMarkNeg};
      next_histNeg = {histNeg[2:0], txMarkNeg & ~txMarkPos};
    end
  end

  // Each held mark adds its own unit-interval column, so overlapping tails add up.
  always_comb begin
    pulseSum = 10'sh000;
    for (int k = 0; k < 4; k++) begin
      if (histPos[k]) begin
        pulseSum = pulseSum + $signed({3'h0, uiRow[27 - 7 * k -: 7]});
      end else if (histNeg[k]) begin
        pulseSum = pulseSum - $signed({3'h0, uiRow[27 - 7 * k -: 7]});
      end
    end
  end

  // The -7.5 dB default of 17 maps to sixteen sixteenths so that one step is exactly 1/16.
  always_comb begin
    case (lboSel)
      LBO_7P5: scaleNum = (effScale == 6'h00) ? 7'h00 : {1'b0, effScale - 6'h01};
      default: scaleNum = {1'b0, effScale};
    endcase
    scaledProd = pulseSum * $signed(scaleNum);
    case (lboSel)
      LBO_7P5: scaledOut = scaledProd >>> 4;
      LBO_15: scaledOut = scaledProd >>> 3;
      LBO_22P5: scaledOut = scaledProd >>> 2;
      default: scaledOut = 17'sh00000;
    endcase
    next_dacCode = scaledOut[13:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sampleIdx <= LAST_SAMPLE;
      histPos <= 4'h0;
      histNeg <= 4'h0;
      lineDacCode <= 14'sh0000;
      lineOutPosDrive <= 1'b0;
      lineOutNegDrive <= 1'b0;
      lineOutPosOe <= 1'b0;
      lineOutNegOe <= 1'b0;
      txPowerDown <= 1'b0;
      internalTermEnable <= 1'b0;
      termImpedanceSel <= IMP_75;
    end else begin
      sampleIdx <= next_sampleIdx;
      histPos <= next_histPos;
      histNeg <= next_histNeg;
      lineDacCode <= next_dacCode;
      lineOutPosDrive <= ~lineHighZ & (next_dacCode > 14'sh0000);
      lineOutNegDrive <= ~lineHighZ & (next_dacCode < 14'sh0000);
      lineOutPosOe <= ~lineHighZ;
      lineOutNegOe <= ~lineHighZ;
      txPowerDown <= effPowerDown;
      internalTermEnable <= effInternalTerm;
      termImpedanceSel <= effImpedance;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_thz_bit_tristate: assert property (!hwMode && highZ |=> !lineOutPosOe && !lineOutNegOe)
    else $error("High-impedance bit did not tri-state the line outputs.");
  chk_thz_pin_tristate: assert property (hwMode && pinSync[PIN_HIGH_Z] |=> !lineOutPosOe && !lineOutNegOe)
    else $error("High-impedance pin did not tri-state the line outputs.");
  chk_power_off_bit: assert property (!hwMode && powerOff |=> txPowerDown && !lineOutPosOe)
    else $error("Power-off bit did not power down and tri-state.");
  chk_hw_power_pins: assert property (hwMode && pinSync[PIN_PATT_HI] && pinSync[PIN_PATT_LO] |=> txPowerDown)
    else $error("Pattern pins high did not power down the transmit path.");
  chk_int_term_imp: assert property (!rst && !hwMode && !termSel[2] |=>
      internalTermEnable && termImpedanceSel == $past(termSel[1:0]))
    else $error("Internal termination impedance does not follow the select.");
  chk_ext_term_sel: assert property (!hwMode && termSel[2] |=> !internalTermEnable)
    else $error("External termination did not disable internal matching.");
  chk_hw_term_pin: assert property (hwMode && !pinSync[PIN_TERM] |=> !internalTermEnable)
    else $error("Termination pin low did not select external matching.");
  chk_scale_default15: assert property (dpValid && dpWrite && dpIndex == REG_TXCFG0_IDX
      && hwdata[3:0] == TPL_LBO_15 && templateSel != TPL_LBO_15 |=> amplitudeScale == SCALE_DEF_15)
    else $error("Scale did not load the -15 dB default.");
  chk_transmit_clock_loss_hiz: assert property (tclkLost && !remoteLoopback && !internalPatternByMclk
      |=> !lineOutPosOe && !lineOutNegOe)
    else $error("Transmit clock loss did not tri-state the line outputs.");
  chk_reset_hold_hiz: assert property (resetHold
      |=> !lineOutPosOe && !lineOutNegOe)
    else $error("Line outputs enabled while reset hold is active.");
  chk_ui_sample_walk: assert property (tclkRise && !effPowerDown
      |=> sampleIdx == 4'h0 ##1 sampleIdx == 4'h1)
    else $error("Sample index did not restart at a unit interval.");

endmodule // tpsl_tx_line_ctrl

//--- bench/tpsl_line_model.sv
// Line transformer and cable model seen from the two line driver outputs.
`timescale 1ns/1ps
module tpsl_line_model (
  // Driver side
  input wire logic posDrive,
  input wire logic posOe,
  input wire logic negDrive,
  input wire logic negOe,
  // Line state
  output logic signed [1:0] lineLevel,
  output logic lineFloat
);
  // A released winding is pulled to the centre tap by the termination, so it reads zero, never the last level.
  assign lineFloat = !(posOe || negOe);
  assign lineLevel = 2'(posOe && posDrive) - 2'(negOe && negDrive);
endmodule // tpsl_line_model

//--- bench/tb_top.sv
// Self-checking bench for the transmit line control block.
`timescale 1ns/1ps
module tb_top import tpsl_pkg::*;;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, posDrv, posOe, negDrv, negOe;
  logic [1:0] htrans = 0, termImpedanceSel;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic hwControlMode = 0, terminationModePin = 1, txHighZPin = 0, patternSelectHi = 0, patternSelectLo = 0;
  logic transmitClock = 0, masterClockLost = 0, remoteLoopback = 0, internalPatternByMclk = 0, txMarkPos = 0;
  logic txRun = 1, txPowerDown, internalTermEnable, lineFloat, txMarkNeg = 0;
  logic signed [1:0] lvl;
  logic [3:0] pulseTemplatePins = 0;
  logic signed [13:0] lineDacCode;
  logic [3:0] tp [3] = '{TPL_LBO_7P5, TPL_LBO_15, TPL_LBO_22P5};
  logic [5:0] sd [3] = '{SCALE_DEF_7P5, SCALE_DEF_15, SCALE_DEF_22P5};
  logic [1:0] imp [4] = '{IMP_75, IMP_120, IMP_100, IMP_110};
  int err_total = 0, checks_done = 0, cyc = 0, tck = 0;

  always #20 ref_clk = ~ref_clk;
  // The transmit clock runs at 20 reference cycles a period and parks low while stopped.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tck <= (tck == 9) ? 0 : tck + 1;
    if (tck == 9) transmitClock <= txRun & ~transmitClock;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  tpsl_tx_line_ctrl dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hwControlMode(hwControlMode), .terminationModePin(terminationModePin),
    .pulseTemplatePins(pulseTemplatePins), .txHighZPin(txHighZPin), .patternSelectHi(patternSelectHi),
    .patternSelectLo(patternSelectLo), .transmitClock(transmitClock), .masterClockLost(masterClockLost),
    .remoteLoopback(remoteLoopback), .internalPatternByMclk(internalPatternByMclk), .txMarkPos(txMarkPos),
    .txMarkNeg(txMarkNeg), .lineOutPosDrive(posDrv), .lineOutPosOe(posOe), .lineOutNegDrive(negDrv),
    .lineOutNegOe(negOe), .lineDacCode(lineDacCode), .txPowerDown(txPowerDown),
    .internalTermEnable(internalTermEnable), .termImpedanceSel(termImpedanceSel));
  tpsl_line_model line (.posDrive(posDrv), .posOe(posOe), .negDrive(negDrv), .negOe(negOe), .lineLevel(lvl),
    .lineFloat(lineFloat));

  // ==========================================================================
  // Bus and check tasks
  // Read data is taken at the same rising edge at which ready is seen high, before that edge updates it.
  task wt;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task bus(input logic w, input logic [5:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, i, 2'h0};
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [5:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task rd(input logic [5:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(q, e);
  endtask
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One mark of either polarity, then the largest converter magnitude and the line level seen with it.
  task peak(input logic neg, input logic [31:0] e);
    logic signed [13:0] p;
    logic signed [1:0] lv;
    p = 0;
    lv = 0;
    txMarkPos <= ~neg;
    txMarkNeg <= neg;
    for (int i = 0; i < 120; i++) begin
      @(negedge ref_clk);
      if ((neg ? -lineDacCode : lineDacCode) > p) begin
        p = neg ? -lineDacCode : lineDacCode;
        lv = lvl;
      end
      @(posedge ref_clk);
      if (i == 19) begin
        txMarkPos <= 1'b0;
        txMarkNeg <= 1'b0;
      end
    end
    chk(32'(p), e);
    chk(32'(lv), neg ? 32'hffffffff : 32'h00000001);
  endtask
  task complete_run;
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    chk(32'(lineFloat), 32'h1);
    rd(REG_TERM_IDX, 32'(TERM_RST));
    rd(6'h3f, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(REG_TXCFG0_IDX, 32'(tp[i]));
      rd(REG_TXCFG1_IDX, 32'(sd[i]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(REG_TERM_IDX, 32'(i));
      idle(3);
      chk(32'(internalTermEnable), 32'h1);
      chk(32'(termImpedanceSel), 32'(imp[i]));
    end
    // External termination is only chosen with an E1 template selected.
    wr(REG_TXCFG0_IDX, 32'(TPL_E1_120));
    wr(REG_TERM_IDX, 32'h4);
    idle(3);
    chk(32'(internalTermEnable), 32'h0);
    wr(REG_TERM_IDX, 32'h0);
    wr(REG_TXCFG0_IDX, 32'(TPL_LBO_15));
    peak(1'b0, 32'h38);
    wr(REG_TXCFG1_IDX, 32'h10);
    peak(1'b0, 32'h70);
    wr(REG_TXCFG0_IDX, 32'(TPL_LBO_22P5));
    peak(1'b1, 32'h32);
    chk(32'(lineFloat), 32'h0);
    wr(REG_TXCFG1_IDX, 32'h44);
    idle(3);
    chk(32'(lineFloat), 32'h1);
    wr(REG_TXCFG1_IDX, 32'h04);
    wr(REG_TXCFG0_IDX, 32'h1b);
    idle(3);
    chk(32'(txPowerDown), 32'h1);
    chk(32'(lineFloat), 32'h1);
    wr(REG_TXCFG0_IDX, 32'h0b);
    masterClockLost <= 1'b1;
    idle(6);
    chk(32'(lineFloat), 32'h1);
    masterClockLost <= 1'b0;
    txRun <= 1'b0;
    idle(70);
    chk(32'(lineFloat), 32'h1);
    rd(REG_STATUS_IDX, 32'h13);
    remoteLoopback <= 1'b1;
    idle(4);
    chk(32'(lineFloat), 32'h0);
    remoteLoopback <= 1'b0;
    internalPatternByMclk <= 1'b1;
    idle(4);
    chk(32'(lineFloat), 32'h0);
    // The internal pattern stays on so that only the re-armed reset hold can float the line here.
    wr(REG_SOFTRST_IDX, 32'h1);
    idle(3);
    chk(32'(lineFloat), 32'h1);
    rd(REG_TXCFG1_IDX, 32'(SCALE_RST));
    internalPatternByMclk <= 1'b0;
    txRun <= 1'b1;
    hwControlMode <= 1'b1;
    txHighZPin <= 1'b1;
    idle(40);
    chk(32'(lineFloat), 32'h1);
    txHighZPin <= 1'b0;
    patternSelectHi <= 1'b1;
    patternSelectLo <= 1'b1;
    idle(6);
    chk(32'(txPowerDown), 32'h1);
    patternSelectLo <= 1'b0;
    terminationModePin <= 1'b0;
    idle(6);
    chk(32'(internalTermEnable), 32'h0);
    terminationModePin <= 1'b1;
    idle(6);
    chk(32'(internalTermEnable), 32'h1);
    chk(32'(termImpedanceSel), 32'(IMP_75));
    complete_run();
  end
endmodule // tb_top
